//--- fsp_ctrl.sv
// flash control register, launch sequencer and space mapping
`timescale 1ns/1ps
`include "fsp_consts.svh"
module fsp_ctrl #(
    parameter int PROG_CYCLES = `FSP_PROG_CYCLES,
    parameter logic [2:0] LOCK_DEFAULT = 3'b011
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // special function register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_rd,
    output logic [7:0] o_sfr_rdata,
    // core status
    input wire logic i_exec_boot_bank,
    input wire logic i_instr_boundary,
    input wire logic i_exec_external,
    input wire logic [15:0] i_pc,
    input wire logic i_external_access_pin,
    // code read path
    input wire logic i_code_rd,
    input wire logic [15:0] i_code_addr,
    // flash array
    input wire logic i_prog_done,
    input wire logic [7:0] i_sec_byte,
    // mapping and programming outputs
    output logic o_latch_map_select,
    output logic o_map_xrow,
    output logic o_map_sec,
    output logic o_prog_start,
    output logic [1:0] o_prog_space,
    output logic o_prog_in_progress_flag,
    output logic o_code_read_block,
    output logic o_ext_exec_block,
    output logic o_par_prog_block,
    output logic o_par_verify_block,
    output logic o_ea_latched
);
    // every flip-flop of the block lives in this one struct
    typedef struct packed {
        fsp_pkg::fsp_state_t state;
        logic [3:0] key;
        logic map;
        logic [1:0] mode;
        logic [31:0] cnt;
        logic start;
        logic [7:0] rdata;
        logic ea;
        logic ea_taken;
    } fsp_st_t;

    fsp_st_t st_reg;
    fsp_st_t st_next;
    fsp_lock_if lk ();
    logic reg_hit;
    logic reg_wr;
    logic [7:0] flash_control;
    logic [3:0] wkey;
    logic [1:0] wmode;
    logic busy;
    logic key_first;
    logic key_second;
    logic launch_ok;
    logic code_in_user;
    logic code_in_xrow;
    logic code_at_sec;
    logic pc_past_user;

    fsp_lock_decode u_lock (
        .lk(lk)
    );

    // ==========================================================
    // lock level
    // the security byte is not trusted while reset holds, so the shipped
    // level applies then; all ones afterwards is level 1, not the default
    assign lk.lock_bits = i_rst_n ? i_sec_byte[2:0] : LOCK_DEFAULT;

    // ==========================================================
    // register decode
    assign reg_hit = (i_sfr_addr == `FSP_FLASH_CONTROL_ADDR);
    assign reg_wr = reg_hit && i_sfr_wr;
    assign wkey = i_sfr_wdata[`FSP_KEY_MSB:`FSP_KEY_LSB];
    assign wmode = i_sfr_wdata[`FSP_MODE_MSB:`FSP_MODE_LSB];
    assign busy = (st_reg.state == fsp_pkg::FSP_ST_BUSY);
    // bit 0 is status only; the written value is dropped
    assign flash_control = {st_reg.key, st_reg.map, st_reg.mode, busy};

    // ==========================================================
    // launch key decode
    // keys written from the user bank act as plain writes
    assign key_first = (wkey == `FSP_KEY_FIRST) && i_exec_boot_bank;
    assign key_second = (wkey == `FSP_KEY_SECOND) && i_exec_boot_bank;
    // second key must repeat the armed mode; reserved mode never launches
    assign launch_ok = key_second && (wmode == st_reg.mode)
        && (st_reg.mode != fsp_pkg::FSP_SPACE_RSVD);

    // ==========================================================
    // address windows
    assign code_in_user = (i_code_addr <= `FSP_USER_TOP);
    assign code_in_xrow = (i_code_addr >= `FSP_XROW_BASE);
    assign code_at_sec = (i_code_addr == `FSP_SEC_ADDR);
    assign pc_past_user = (i_pc > `FSP_USER_TOP);

    // ==========================================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.start = 1'b0;
        st_next.rdata = (reg_hit && i_sfr_rd) ? flash_control : 8'h00;
        // external access pin is caught once, at the first edge after reset
        if (!st_reg.ea_taken) begin
            st_next.ea = i_external_access_pin;
            st_next.ea_taken = 1'b1;
        end
        case (st_reg.state)
            fsp_pkg::FSP_ST_IDLE: begin
                if (reg_wr) begin
                    st_next.key = wkey;
                    st_next.map = i_sfr_wdata[`FSP_MAP_BIT];
                    st_next.mode = wmode;
                    // launch keys only honoured from boot bank
                    if (key_first) begin
                        st_next.state = fsp_pkg::FSP_ST_ARMED;
                    end
                end
            end
            fsp_pkg::FSP_ST_ARMED: begin
                if (reg_wr) begin
                    st_next.key = wkey;
                    st_next.map = i_sfr_wdata[`FSP_MAP_BIT];
                    st_next.mode = wmode;
                    if (launch_ok) begin
                        st_next.state = fsp_pkg::FSP_ST_BUSY;
                        st_next.start = 1'b1;
                        st_next.cnt = 32'(PROG_CYCLES);
                    end else if (key_first) begin
                        // a repeated first key re-arms with the new mode
                        st_next.state = fsp_pkg::FSP_ST_ARMED;
                    end else begin
                        st_next.state = fsp_pkg::FSP_ST_IDLE;
                    end
                end else if (i_instr_boundary) begin
                    // another instruction came between the keys
                    st_next.state = fsp_pkg::FSP_ST_IDLE;
                end
            end
            fsp_pkg::FSP_ST_BUSY: begin
                // register writes ignored while programming
                // counter is a backstop: a lost done pulse must not leave busy stuck
                if (st_reg.cnt != 32'h0) begin
                    st_next.cnt = st_reg.cnt - 32'h1;
                end
                if (i_prog_done || st_reg.cnt == 32'h1) begin
                    st_next.state = fsp_pkg::FSP_ST_IDLE;
                    st_next.key = 4'h0;
                    st_next.cnt = 32'h0;
                end
            end
            default: st_next.state = fsp_pkg::FSP_ST_IDLE;
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs
    assign o_sfr_rdata = st_reg.rdata;
    assign o_latch_map_select = st_reg.map;
    // steering is combinational so the code read in flight sees the map at once;
    // it is held off while busy, as the array is not readable mid-programme
    assign o_map_xrow = (st_reg.mode == fsp_pkg::FSP_SPACE_XROW)
        && !busy
        && i_code_rd && code_in_xrow;
    assign o_map_sec = (st_reg.mode == fsp_pkg::FSP_SPACE_SEC)
        && !busy
        && i_code_rd && code_at_sec;
    assign o_prog_start = st_reg.start;
    assign o_prog_space = st_reg.mode;
    assign o_prog_in_progress_flag = busy;
    // protection follows the lock bits with no register, so a new
    // security byte takes effect on the very next access
    assign o_code_read_block = lk.no_ext_code_read_instr && i_exec_external && i_code_rd
        && code_in_user;
    assign o_ext_exec_block = lk.rollover_block && !i_exec_external
        && pc_past_user;
    assign o_par_prog_block = lk.par_prog_block;
    assign o_par_verify_block = lk.par_verify_block;
    assign o_ea_latched = st_reg.ea;
endmodule

//--- fsp_consts.svh
// constants of the flash space programming controller
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
// ==========================================================
// register map
`define FSP_FLASH_CONTROL_ADDR 8'hD1
`define FSP_FLASH_CONTROL_RST 8'h00
// ==========================================================
// field positions
`define FSP_KEY_MSB 7
`define FSP_KEY_LSB 4
`define FSP_MAP_BIT 3
`define FSP_MODE_MSB 2
`define FSP_MODE_LSB 1
`define FSP_BUSY_BIT 0
// ==========================================================
// launch key nibbles and map values
`define FSP_KEY_FIRST 4'h5
`define FSP_KEY_SECOND 4'hA
`define FSP_MAP_XROW 8'h02
`define FSP_MAP_SEC 8'h04
// ==========================================================
// address windows
`define FSP_USER_TOP 16'h7FFF
`define FSP_XROW_BASE 16'hFF80
`define FSP_SEC_ADDR 16'h0000
// ==========================================================
// timing
`define FSP_PROG_TIME_US 2000
`define FSP_CLK_MHZ 100
`define FSP_PROG_CYCLES (`FSP_PROG_TIME_US * `FSP_CLK_MHZ)
`endif

//--- fsp_pkg.sv
// types of the flash space programming controller
package fsp_pkg;
    typedef enum logic [1:0] {
        FSP_SPACE_USER,
        FSP_SPACE_XROW,
        FSP_SPACE_SEC,
        FSP_SPACE_RSVD
    } fsp_space_t;

    typedef enum logic [1:0] {
        FSP_ST_IDLE,
        FSP_ST_ARMED,
        FSP_ST_BUSY
    } fsp_state_t;
endpackage

//--- fsp_lock_if.sv
// lock level interface between controller and lock decoder
`timescale 1ns/1ps
interface fsp_lock_if;
    logic [2:0] lock_bits;
    logic no_ext_code_read_instr;
    logic par_prog_block;
    logic par_verify_block;
    logic rollover_block;
    modport decoder (input lock_bits, output no_ext_code_read_instr, output par_prog_block,
        output par_verify_block, output rollover_block);
    modport ctrl (output lock_bits, input no_ext_code_read_instr, input par_prog_block,
        input par_verify_block, input rollover_block);
endinterface

//--- fsp_lock_decode.sv
// decodes the security byte lock bits into protection controls
`timescale 1ns/1ps
module fsp_lock_decode (
    fsp_lock_if.decoder lk
);
    // lock bits are active low: 0 means programmed
    always_comb begin
        lk.no_ext_code_read_instr = 1'b0;
        lk.par_prog_block = 1'b0;
        lk.par_verify_block = 1'b0;
        lk.rollover_block = 1'b0;
        if (!lk.lock_bits[2]) begin
            lk.no_ext_code_read_instr = 1'b1;
            lk.par_prog_block = 1'b1;
            lk.par_verify_block = 1'b1;
            lk.rollover_block = 1'b1;
        end else if (!lk.lock_bits[1]) begin
            lk.no_ext_code_read_instr = 1'b1;
            lk.par_prog_block = 1'b1;
            lk.par_verify_block = 1'b1;
        end else if (!lk.lock_bits[0]) begin
            lk.no_ext_code_read_instr = 1'b1;
            lk.par_prog_block = 1'b1;
        end
        // all unprogrammed: level 1, nothing barred
    end
endmodule

//--- fsp_array_model.sv
// flash array model: answers a launch with a done pulse
`timescale 1ns/1ps
module fsp_array_model (
    // clock and controller side
    input wire logic i_core_clk,
    input wire logic i_prog_start,
    input wire logic i_stall,
    output logic o_prog_done = 1'b0
);
    int cnt = 0;
    // stall withholds done so the controller's own limit ends the operation
    always @(posedge i_core_clk) begin
        cnt <= i_prog_start ? 5 : (cnt > 0 ? cnt - 1 : 0);
        o_prog_done <= (cnt == 1) && !i_stall;
    end
endmodule

//--- fsp_ctrl_assertions.sv
// assertions on the flash control block ports
`timescale 1ns/1ps
module fsp_ctrl_assertions (
    // clock, reset and register port
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_rd,
    input wire logic [7:0] o_sfr_rdata,
    // core, array and launch
    input wire logic i_exec_boot_bank,
    input wire logic i_instr_boundary,
    input wire logic i_prog_done,
    input wire logic o_latch_map_select,
    input wire logic o_prog_start,
    input wire logic [1:0] o_prog_space,
    input wire logic o_prog_in_progress_flag
);
    logic wr_ok;
    logic key2;
    assign wr_ok = i_sfr_wr && i_sfr_addr == 8'hD1 && !o_prog_in_progress_flag;
    assign key2 = wr_ok && i_sfr_wdata[7:4] == 4'hA && i_exec_boot_bank;
    // ==========================================================
    // properties
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    chk_reset_zero: assert property ($rose(i_rst_n) |-> o_sfr_rdata == 8'h00)
        else $error("register not clear after reset");
    chk_start_busy: assert property (o_prog_start |-> o_prog_in_progress_flag)
        else $error("start pulse without busy");
    chk_start_key: assert property ($rose(o_prog_in_progress_flag) |-> $past(key2))
        else $error("busy rose without a second key write");
    chk_key_gap: assert property (o_prog_start |-> !$past(i_instr_boundary))
        else $error("launch after an instruction between keys");
    chk_done_clear: assert property (o_prog_in_progress_flag && i_prog_done
        |=> !o_prog_in_progress_flag) else $error("busy held after done");
    chk_map_follow: assert property (wr_ok |=> o_latch_map_select == $past(i_sfr_wdata[3]))
        else $error("map select does not follow bit 3");
    chk_busy_read: assert property (i_sfr_rd && i_sfr_addr == 8'hD1
        |=> o_sfr_rdata[0] == $past(o_prog_in_progress_flag)) else $error("busy bit read wrong");
    chk_space_legal: assert property (o_prog_start |-> o_prog_space != 2'b11)
        else $error("reserved space launched");
endmodule
bind fsp_ctrl fsp_ctrl_assertions i_fsp_ctrl_assertions (.i_core_clk, .i_rst_n, .i_sfr_addr,
    .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata, .i_exec_boot_bank, .i_instr_boundary,
    .i_prog_done, .o_latch_map_select, .o_prog_start, .o_prog_space, .o_prog_in_progress_flag);

//--- fsp_ctrl_test.sv
// self-checking bench for the flash control block
`timescale 1ns/1ps
module fsp_ctrl_test;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, stall = 1'b0;
    logic i_exec_boot_bank = 1'b1, i_instr_boundary = 1'b0, i_exec_external = 1'b0;
    logic i_external_access_pin = 1'b1, i_code_rd = 1'b1, i_prog_done;
    logic [7:0] i_sfr_addr = 8'hD1, i_sfr_wdata = 8'h00, i_sec_byte = 8'hFF, o_sfr_rdata;
    logic [15:0] i_pc = 16'h0000, i_code_addr = 16'h0000;
    logic [1:0] o_prog_space;
    logic o_latch_map_select, o_map_xrow, o_map_sec, o_prog_start, o_prog_in_progress_flag;
    logic o_code_read_block, o_ext_exec_block, o_par_prog_block, o_par_verify_block, o_ea_latched;
    logic [7:0] key_a [4] = '{8'h50, 8'h56, 8'h50, 8'h50};
    logic [7:0] key_b [4] = '{8'hA0, 8'hA6, 8'hA2, 8'hA0};
    logic [2:0] lock_val [4] = '{3'b111, 3'b110, 3'b101, 3'b011};
    int errors = 0;
    int samples_checked = 0;
    always #5 i_core_clk = ~i_core_clk;
    fsp_ctrl #(.PROG_CYCLES(20)) i_fsp_ctrl (.i_core_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wr,
        .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata, .i_exec_boot_bank, .i_instr_boundary,
        .i_exec_external, .i_pc, .i_external_access_pin, .i_code_rd, .i_code_addr,
        .i_prog_done, .i_sec_byte, .o_latch_map_select, .o_map_xrow, .o_map_sec,
        .o_prog_start, .o_prog_space, .o_prog_in_progress_flag, .o_code_read_block,
        .o_ext_exec_block, .o_par_prog_block, .o_par_verify_block, .o_ea_latched);
    fsp_array_model i_fsp_array_model (.i_core_clk, .i_prog_start(o_prog_start),
        .i_stall(stall), .o_prog_done(i_prog_done));
    // ==========================================================
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // last lowers the strobe; key writes keep it high to stay back to back
    task automatic wr(input logic [7:0] d, input bit last);
        i_sfr_wr <= 1'b1;
        i_sfr_wdata <= d;
        @(posedge i_core_clk);
        if (last) i_sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] exp);
        i_sfr_rd <= 1'b1;
        @(posedge i_core_clk);
        i_sfr_rd <= 1'b0;
        #1 chk(o_sfr_rdata, exp);
        @(posedge i_core_clk);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        repeat (5) @(posedge i_core_clk);
        // shipped protection level applies while reset holds
        #1 chk({5'h00, o_code_read_block, o_par_prog_block, o_par_verify_block}, 8'h03);
        @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        rd(8'h00);
        i_external_access_pin <= 1'b0;
        $display("reset test done");
        for (int m = 0; m < 3; m++) begin
            stall <= (m == 1);
            if (m == 2) wr(8'h0C, 1'b1);
            #1 chk({7'h00, o_latch_map_select}, {7'h00, m == 2});
            @(posedge i_core_clk);
            wr({4'h5, 1'b0, m[1:0], 1'b0}, 1'b0);
            wr({4'hA, 1'b0, m[1:0], 1'b0}, 1'b1);
            #1 chk({4'h0, o_prog_start, o_prog_in_progress_flag, o_prog_space}, {6'h03, m[1:0]});
            @(posedge i_core_clk);
            wr(8'h00, 1'b1);
            rd({4'hA, 1'b0, m[1:0], 1'b1});
            for (int n = 0; n < 40 && o_prog_in_progress_flag; n++) @(posedge i_core_clk);
            @(posedge i_core_clk);
            rd(8'h00 | {5'h00, m[1:0], 1'b0});
        end
        $display("launch test done");
        for (int c = 0; c < 4; c++) begin
            i_exec_boot_bank <= (c != 0);
            wr(key_a[c], c == 3);
            if (c == 3) begin
                i_instr_boundary <= 1'b1;
                @(posedge i_core_clk);
                i_instr_boundary <= 1'b0;
            end
            wr(key_b[c], 1'b1);
            repeat (2) @(posedge i_core_clk);
            #1 chk({7'h00, o_prog_in_progress_flag}, 8'h00);
            @(posedge i_core_clk);
        end
        i_sfr_addr <= 8'hD0;
        rd(8'h00);
        i_sfr_addr <= 8'hD1;
        $display("refusal test done");
        for (int j = 0; j < 3; j++) begin
            wr(8'h02 << j, 1'b1);
            i_code_addr <= (j == 0) ? 16'hFF80 : 16'h0000;
            #1 chk({6'h00, o_map_xrow, o_map_sec}, 8'h02 >> j);
            @(posedge i_core_clk);
        end
        // mapped extra row must not steer when no code read is running
        wr(8'h02, 1'b1);
        i_code_rd <= 1'b0;
        i_code_addr <= 16'hFF80;
        #1 chk({6'h00, o_map_xrow, o_map_sec}, 8'h00);
        @(posedge i_core_clk);
        i_code_rd <= 1'b1;
        i_code_addr <= 16'h0000;
        wr(8'h00, 1'b1);
        $display("map test done");
        for (int l = 0; l < 4; l++) begin
            i_sec_byte <= {5'h1F, lock_val[l]};
            i_exec_external <= 1'b1;
            i_pc <= 16'h0000;
            @(posedge i_core_clk);
            #1 chk({5'h00, o_code_read_block, o_par_prog_block, o_par_verify_block},
                {5'h00, l > 0, l > 0, l > 1});
            @(posedge i_core_clk);
            i_exec_external <= 1'b0;
            i_pc <= 16'h8000;
            @(posedge i_core_clk);
            #1 chk({7'h00, o_ext_exec_block}, {7'h00, l == 3});
            @(posedge i_core_clk);
        end
        chk({7'h00, o_ea_latched}, 8'h01);
        $display("lock test done");
        results;
    end
    // tests need well under a thousand cycles
    initial begin
        #100000;
        errors++;
        results;
    end
endmodule
